// [rtl/aic_pkg.sv]
// Purpose: shared constants of the accelerometer interrupt controller
// Assumes: core clock of 10 MHz
// Notes: byte register map, engine numbering, hold-mode codes, timing figures
package aic_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned TMR_W = 27;
    localparam int unsigned NEWS_LOW_US = 50;
    localparam int unsigned NEWS_LOW_CYC = NEWS_LOW_US * CLK_MHZ;
    localparam int unsigned FIXED_CLR_US = 12500;
    localparam int unsigned WAKE_SETTLE_US = 2000;
    localparam int unsigned TMP_US [0:11] = '{250000, 500000, 1000000, 2000000, 4000000,
        8000000, 250, 500, 1000, 12500, 25000, 50000};

    function automatic int unsigned cyc_of(input int unsigned us);
        return us * CLK_MHZ;
    endfunction

    localparam int unsigned TMP_CYC_DEF [0:11] = '{cyc_of(TMP_US[0]), cyc_of(TMP_US[1]),
        cyc_of(TMP_US[2]), cyc_of(TMP_US[3]), cyc_of(TMP_US[4]), cyc_of(TMP_US[5]),
        cyc_of(TMP_US[6]), cyc_of(TMP_US[7]), cyc_of(TMP_US[8]), cyc_of(TMP_US[9]),
        cyc_of(TMP_US[10]), cyc_of(TMP_US[11])};
    localparam int unsigned FIXED_CLR_CYC_DEF = cyc_of(FIXED_CLR_US);
    localparam int unsigned WAKE_SETTLE_CYC_DEF = cyc_of(WAKE_SETTLE_US);

    // ==========================================================
    // register map
    localparam logic [7:0] OFS_FRESH_FLAG = 8'h0a;
    localparam logic [7:0] OFS_FRESH_EN = 8'h17;
    localparam logic [7:0] OFS_PIN_A_ROUTE = 8'h19;
    localparam logic [7:0] OFS_PIN_B_ROUTE = 8'h1b;
    localparam logic [7:0] OFS_SRC_SEL = 8'h1e;
    localparam logic [7:0] OFS_PIN_CFG = 8'h20;
    localparam logic [7:0] OFS_HOLD = 8'h21;
    localparam logic [7:0] RST_REG = 8'h00;

    // ==========================================================
    // engine numbering and field positions
    localparam int unsigned ENG_FRESH = 0;
    localparam int unsigned ENG_ORIENT = 6;
    localparam int unsigned ENG_LEVEL_POSE = 7;
    localparam logic [7:0] SRC_FIXED_MASK = 8'h3f;
    localparam int unsigned PCFG_A_POL = 0;
    localparam int unsigned PCFG_A_OD = 1;
    localparam int unsigned PCFG_B_POL = 2;
    localparam int unsigned PCFG_B_OD = 3;
    localparam int unsigned HOLD_CLR_BIT = 7;
    localparam logic [2:0] HOLD_NONLATCH = 3'h0;
    localparam logic [2:0] HOLD_LATCH = 3'h7;
endpackage

// [rtl/aic_top.sv]
// Purpose: interrupt controller of a triaxial accelerometer, eight engines to two pins
// Assumes: engine conditions and strobes come from logic on core_clk
// Notes: register port is a simple synchronous write/read strobe pair
// How it works
// - eight engines, each enabled on its own
// - enabled trigger sets status, drives mapped pins
// - two pins, each OR of mapped engines
// - status set only at sample update
// - disabling an engine clears its status immediately
// - one hold field; nonlatched and latched codes
// - temporary codes clear after selected delay
// - no timed or nonlatched clear while activation still holds
// - nonlatched drops status at the first sample update after condition ends
// - orientation, flat clear after fixed time when nonlatched
// - latched status held until clear bit written
// - still-true condition re-asserts at next update
// - source-select bits choose filtered or unfiltered
// - orientation and flat always use filtered samples
// - routing registers map engines to pins
// - polarity bit per pin, one active high
// - driver bit per pin, one open drain
// - new-sample raised once z value stored
// - new-sample cleared at acquisition start, low 50us
// - new-sample always nonlatched, own enable/status
// - first new-sample after wake is delayed
`timescale 1ns/1ps
module aic_top
    import aic_pkg::*;
#(
    parameter int unsigned TMP_CYC [0:11] = TMP_CYC_DEF,
    parameter int unsigned FIXED_CLR_CYC = FIXED_CLR_CYC_DEF,
    parameter int unsigned WAKE_SETTLE_CYC = WAKE_SETTLE_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sample_upd,
    input wire logic acq_start,
    input wire logic wake_evt,
    input wire logic [7:1] eng_cond,
    output logic [7:0] src_unfilt,
    output logic irq_pin_a,
    output logic irq_pin_a_oe,
    output logic irq_pin_b,
    output logic irq_pin_b_oe
);
    // ==========================================================
    // registers
    logic [7:0] en_q, en_d, rt_a_q, rt_a_d, rt_b_q, rt_b_d;
    logic [7:0] src_q, src_d, pcfg_q, pcfg_d, hold_q, hold_d, rdata_q, rdata_d;
    // status bits come from per-engine flops, one driver each, gathered on a net
    wire logic [7:0] st_q;
    logic clr_latch;

    always_comb begin
        en_d = en_q;
        rt_a_d = rt_a_q;
        rt_b_d = rt_b_q;
        src_d = src_q;
        pcfg_d = pcfg_q;
        hold_d = hold_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_FRESH_EN: en_d = reg_wdata;
                OFS_PIN_A_ROUTE: rt_a_d = reg_wdata;
                OFS_PIN_B_ROUTE: rt_b_d = reg_wdata;
                OFS_SRC_SEL: src_d = reg_wdata & SRC_FIXED_MASK;
                OFS_PIN_CFG: pcfg_d = {4'h0, reg_wdata[3:0]};
                OFS_HOLD: hold_d = {4'h0, reg_wdata[3:0]};
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_FRESH_FLAG: rdata_d = st_q;
                OFS_FRESH_EN: rdata_d = en_q;
                OFS_PIN_A_ROUTE: rdata_d = rt_a_q;
                OFS_PIN_B_ROUTE: rdata_d = rt_b_q;
                OFS_SRC_SEL: rdata_d = src_q;
                OFS_PIN_CFG: rdata_d = pcfg_q;
                OFS_HOLD: rdata_d = hold_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= RST_REG;
            rt_a_q <= RST_REG;
            rt_b_q <= RST_REG;
            src_q <= RST_REG;
            pcfg_q <= RST_REG;
            hold_q <= RST_REG;
            rdata_q <= RST_REG;
        end else begin
            en_q <= en_d;
            rt_a_q <= rt_a_d;
            rt_b_q <= rt_b_d;
            src_q <= src_d;
            pcfg_q <= pcfg_d;
            hold_q <= hold_d;
            rdata_q <= rdata_d;
        end
    end

    // the clear bit is write-only: it acts as a one-cycle pulse and reads back as zero
    assign clr_latch = reg_wr && (reg_addr == OFS_HOLD) && reg_wdata[HOLD_CLR_BIT];
    assign reg_rdata = rdata_q;
    assign src_unfilt = src_q;

    // ==========================================================
    // hold mode decode
    logic mode_nonlatch, mode_latch, mode_temp;
    logic [3:0] tmp_idx;
    logic [TMR_W-1:0] tmp_load;

    assign mode_nonlatch = (hold_q[2:0] == HOLD_NONLATCH);
    assign mode_latch = (hold_q[2:0] == HOLD_LATCH);
    assign mode_temp = !mode_nonlatch && !mode_latch;
    // codes 1..6 and 9..14 index the twelve temporary delays
    assign tmp_idx = hold_q[3] ? 4'(hold_q[2:0] + 3'h5) : 4'(hold_q[2:0] - 3'h1);
    assign tmp_load = mode_temp ? TMR_W'(TMP_CYC[tmp_idx]) : TMR_W'(FIXED_CLR_CYC);

    // ==========================================================
    // motion engines 1..7
    for (genvar i = 1; i < 8; i++) begin : g_eng
        logic st_d, st_bit_q;
        logic timed;
        logic [TMR_W-1:0] tm_q, tm_d;
        assign st_q[i] = st_bit_q;
        // orientation and flat use their own fixed clear time when nonlatched
        assign timed = mode_temp || (mode_nonlatch && (i >= ENG_ORIENT));

        always_comb begin
            st_d = st_q[i];
            tm_d = tm_q;
            if (!en_q[i]) begin
                st_d = 1'b0;
                tm_d = '0;
            end else begin
                if (tm_q != '0) begin
                    tm_d = tm_q - TMR_W'(1);
                end
                // a still-true condition blocks every timed or level clear
                if (timed && st_q[i] && (tm_q <= TMR_W'(1)) && !eng_cond[i]) begin
                    st_d = 1'b0;
                end
                if (!timed && mode_nonlatch && sample_upd && !eng_cond[i]) begin
                    st_d = 1'b0;
                end
                if (mode_latch && clr_latch) begin
                    st_d = 1'b0;
                end
                // set wins over any clear in the same cycle
                if (sample_upd && eng_cond[i]) begin
                    st_d = 1'b1;
                    tm_d = tmp_load;
                end
            end
        end

        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                st_bit_q <= 1'b0;
                tm_q <= '0;
            end else begin
                st_bit_q <= st_d;
                tm_q <= tm_d;
            end
        end
    end

    // ==========================================================
    // fresh-sample engine, bit 0, ignores the hold field
    localparam int unsigned SETTLE_W = $clog2(WAKE_SETTLE_CYC + 1);
    logic st0_d, st0_q;
    assign st_q[ENG_FRESH] = st0_q;
    logic [9:0] low_q, low_d;
    logic [SETTLE_W-1:0] settle_q, settle_d;

    always_comb begin
        st0_d = st_q[ENG_FRESH];
        low_d = (low_q != 10'h000) ? low_q - 10'h001 : low_q;
        settle_d = (settle_q != '0) ? settle_q - SETTLE_W'(1) : settle_q;
        if (wake_evt) begin
            settle_d = SETTLE_W'(WAKE_SETTLE_CYC);
        end
        if (!en_q[ENG_FRESH]) begin
            st0_d = 1'b0;
        end else begin
            if (acq_start && st_q[ENG_FRESH]) begin
                st0_d = 1'b0;
                low_d = 10'(NEWS_LOW_CYC);
            end
            // the low window keeps the flag down long enough for a host to see the edge
            if (sample_upd && (low_q == 10'h000) && (settle_q == '0) && !acq_start) begin
                st0_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st0_q <= 1'b0;
            low_q <= 10'h000;
            settle_q <= '0;
        end else begin
            st0_q <= st0_d;
            low_q <= low_d;
            settle_q <= settle_d;
        end
    end

    // ==========================================================
    // pins
    logic act_a, act_b, pin_a_d, pin_b_d, oe_a_d, oe_b_d;
    logic pin_a_q, pin_b_q, oe_a_q, oe_b_q;

    always_comb begin
        act_a = |(st_q & rt_a_q);
        act_b = |(st_q & rt_b_q);
        pin_a_d = act_a ? pcfg_q[PCFG_A_POL] : !pcfg_q[PCFG_A_POL];
        pin_b_d = act_b ? pcfg_q[PCFG_B_POL] : !pcfg_q[PCFG_B_POL];
        // open drain drives only the active level; the external resistor sets idle
        oe_a_d = pcfg_q[PCFG_A_OD] ? act_a : 1'b1;
        oe_b_d = pcfg_q[PCFG_B_OD] ? act_b : 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_a_q <= 1'b1;
            pin_b_q <= 1'b1;
            oe_a_q <= 1'b1;
            oe_b_q <= 1'b1;
        end else begin
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
            oe_a_q <= oe_a_d;
            oe_b_q <= oe_b_d;
        end
    end

    assign irq_pin_a = pin_a_q;
    assign irq_pin_b = pin_b_q;
    assign irq_pin_a_oe = oe_a_q;
    assign irq_pin_b_oe = oe_b_q;

    // ==========================================================
    // checks
    property p_disable_clears;
        @(posedge core_clk) disable iff (!rstn)
        !en_q[3] |=> !st_q[3];
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disabled engine kept its status");

    property p_set_on_update;
        @(posedge core_clk) disable iff (!rstn)
        en_q[3] && sample_upd && eng_cond[3] |=> st_q[3];
    endproperty
    a_set_on_update: assert property (p_set_on_update)
        else $error("trigger at update did not set status");

    property p_rise_at_update;
        @(posedge core_clk) disable iff (!rstn)
        $rose(st_q[3]) |-> $past(sample_upd);
    endproperty
    a_rise_at_update: assert property (p_rise_at_update)
        else $error("status rose outside a sample update");

    property p_nonlatch_drop;
        @(posedge core_clk) disable iff (!rstn)
        mode_nonlatch && sample_upd && !eng_cond[3] |=> !st_q[3];
    endproperty
    a_nonlatch_drop: assert property (p_nonlatch_drop)
        else $error("nonlatched status not dropped");

    property p_latch_holds;
        @(posedge core_clk) disable iff (!rstn)
        mode_latch && st_q[3] && en_q[3] && !clr_latch ##1 $stable(hold_q) |-> st_q[3];
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latched status cleared without clear write");

    property p_cond_blocks_clear;
        @(posedge core_clk) disable iff (!rstn)
        mode_temp && st_q[3] && en_q[3] && eng_cond[3] ##1 en_q[3] |-> st_q[3];
    endproperty
    a_cond_blocks_clear: assert property (p_cond_blocks_clear)
        else $error("status cleared while condition true");

    property p_pin_a_level;
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> irq_pin_a == ((|($past(st_q) & $past(rt_a_q))) ~^ $past(pcfg_q[PCFG_A_POL]));
    endproperty
    a_pin_a_level: assert property (p_pin_a_level)
        else $error("pin a level disagrees with mapped status");

    property p_pushpull_oe;
        @(posedge core_clk) disable iff (!rstn)
        !pcfg_q[PCFG_B_OD] |=> irq_pin_b_oe;
    endproperty
    a_pushpull_oe: assert property (p_pushpull_oe)
        else $error("push-pull pin b not driven");

    property p_fresh_low_gap;
        @(posedge core_clk) disable iff (!rstn)
        $fell(st_q[ENG_FRESH]) && en_q[ENG_FRESH] |-> !st_q[ENG_FRESH] [*8];
    endproperty
    a_fresh_low_gap: assert property (p_fresh_low_gap)
        else $error("fresh-sample flag reasserted too soon");

    property p_fixed_filtered;
        @(posedge core_clk) disable iff (!rstn)
        src_unfilt[ENG_LEVEL_POSE:ENG_ORIENT] == 2'b00;
    endproperty
    a_fixed_filtered: assert property (p_fixed_filtered)
        else $error("orientation or flat source not filtered");

    property p_temp_expire;
        @(posedge core_clk) disable iff (!rstn)
        mode_temp && en_q[3] && st_q[3] && !eng_cond[3] && (g_eng[3].tm_q == TMR_W'(1))
        |=> !st_q[3];
    endproperty
    a_temp_expire: assert property (p_temp_expire)
        else $error("temporary status outlived its delay");

    property p_latch_clear;
        @(posedge core_clk) disable iff (!rstn)
        mode_latch && clr_latch && en_q[3] && !(sample_upd && eng_cond[3]) |=> !st_q[3];
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("clear write left latched status set");

    property p_pin_b_level;
        @(posedge core_clk) disable iff (!rstn)
        1'b1 |=> irq_pin_b == ((|($past(st_q) & $past(rt_b_q))) ~^ $past(pcfg_q[PCFG_B_POL]));
    endproperty
    a_pin_b_level: assert property (p_pin_b_level)
        else $error("pin b level disagrees with mapped status");

    property p_opendrain_oe;
        @(posedge core_clk) disable iff (!rstn)
        pcfg_q[PCFG_A_OD] |=> irq_pin_a_oe == $past(act_a);
    endproperty
    a_opendrain_oe: assert property (p_opendrain_oe)
        else $error("open-drain pin a driven while idle");

    property p_fresh_set;
        @(posedge core_clk) disable iff (!rstn)
        en_q[ENG_FRESH] && sample_upd && !acq_start && (low_q == 10'h000) && (settle_q == '0)
        |=> st_q[ENG_FRESH];
    endproperty
    a_fresh_set: assert property (p_fresh_set)
        else $error("fresh-sample flag not raised at update");

    property p_fresh_clear;
        @(posedge core_clk) disable iff (!rstn)
        en_q[ENG_FRESH] && acq_start |=> !st_q[ENG_FRESH];
    endproperty
    a_fresh_clear: assert property (p_fresh_clear)
        else $error("fresh-sample flag kept at acquisition start");

    property p_settle_blocks;
        @(posedge core_clk) disable iff (!rstn)
        (settle_q != '0) && !st_q[ENG_FRESH] |=> !st_q[ENG_FRESH];
    endproperty
    a_settle_blocks: assert property (p_settle_blocks)
        else $error("fresh-sample flag raised while filter settles");

    property p_fresh_disable;
        @(posedge core_clk) disable iff (!rstn)
        !en_q[ENG_FRESH] |=> !st_q[ENG_FRESH];
    endproperty
    a_fresh_disable: assert property (p_fresh_disable)
        else $error("disabled fresh-sample flag kept");
endmodule // aic_top

// [test/aic_host_model.sv]
// Purpose: host processor watching the two interrupt pins
// Assumes: each pin carries a resistor pulling it to its idle level
// Notes: reports whether the host sees each resolved wire as active
`timescale 1ns/1ps
module aic_host_model (
    input wire logic pin_a,
    input wire logic pin_a_oe,
    input wire logic pol_a,
    input wire logic pin_b,
    input wire logic pin_b_oe,
    input wire logic pol_b,
    output logic act_a,
    output logic act_b
);
    // ==========================================================
    // wire resolution
    // a released open-drain pin floats to the pull level, never the last value
    // host compares the wire with the configured active level
    assign act_a = ((pin_a_oe ? pin_a : ~pol_a) === pol_a);
    assign act_b = ((pin_b_oe ? pin_b : ~pol_b) === pol_b);
endmodule // aic_host_model

// [test/aic_top_test.sv]
// Purpose: self-checking bench of the accelerometer interrupt controller
// Assumes: shortened hold timers; inputs driven 10 ns after the rising edge
// Notes: pins are judged at the wire through the host model
`timescale 1ns/1ps
module aic_top_test;
    import aic_pkg::*;
    // ==========================================================
    // setup; short timers keep the run to a few thousand cycles
    localparam int unsigned TC [0:11] = '{20, 22, 24, 26, 28, 30, 32, 34, 36, 38, 40, 42};
    localparam int unsigned FCLR = 30;
    localparam int unsigned WSET = 10;
    localparam logic [7:1] C3 = 7'h04;
    localparam logic [7:0] MAP [0:6] = '{OFS_FRESH_FLAG, OFS_FRESH_EN, OFS_PIN_A_ROUTE,
        OFS_PIN_B_ROUTE, OFS_SRC_SEL, OFS_PIN_CFG, OFS_HOLD};
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, src_unfilt;
    logic reg_wr = 1'h0, reg_rd = 1'h0, sample_upd = 1'h0, acq_start = 1'h0, wake_evt = 1'h0;
    logic [7:1] eng_cond = 7'h00;
    logic irq_pin_a, irq_pin_a_oe, irq_pin_b, irq_pin_b_oe, act_a, act_b;
    logic pol_a = 1'h0, pol_b = 1'h0;
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    aic_top #(.TMP_CYC(TC), .FIXED_CLR_CYC(FCLR), .WAKE_SETTLE_CYC(WSET)) u_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_upd(sample_upd),
        .acq_start(acq_start), .wake_evt(wake_evt), .eng_cond(eng_cond),
        .src_unfilt(src_unfilt), .irq_pin_a(irq_pin_a), .irq_pin_a_oe(irq_pin_a_oe),
        .irq_pin_b(irq_pin_b), .irq_pin_b_oe(irq_pin_b_oe));
    aic_host_model u_host (.pin_a(irq_pin_a), .pin_a_oe(irq_pin_a_oe), .pol_a(pol_a),
        .pin_b(irq_pin_b), .pin_b_oe(irq_pin_b_oe), .pol_b(pol_b), .act_a(act_a),
        .act_b(act_b));

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch = n_mismatch + 1;
            summarize();
        end
    end
    // ==========================================================
    // access tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobes stand until the next call, so back-to-back calls never drop and raise one at once
    task automatic drv(input logic w, r, u, a, k);
        reg_wr = w;
        reg_rd = r;
        sample_upd = u;
        acq_start = a;
        wake_evt = k;
        @(posedge core_clk);
        #10;
    endtask
    task automatic step(input int n);
        drv(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        repeat (n - 1) begin
            @(posedge core_clk);
            #10;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        drv(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        drv(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        check(reg_rdata, exp);
    endtask
    task automatic upd(input logic [7:1] c);
        eng_cond = c;
        drv(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        logic [7:0] cfg;
        logic [7:1] c;
        repeat (8) @(posedge core_clk);
        #10;
        rstn = 1'h1;
        check({4'h0, irq_pin_a, irq_pin_a_oe, irq_pin_b, irq_pin_b_oe}, 8'h0f);
        foreach (MAP[i]) rdc(MAP[i], RST_REG);
        wr(8'h55, 8'hff);
        rdc(8'h55, 8'h00);
        wr(OFS_FRESH_FLAG, 8'hff);
        rdc(OFS_FRESH_FLAG, 8'h00);
        for (int i = 1; i < 4; i++) begin
            wr(MAP[i], 8'ha5);
            rdc(MAP[i], 8'ha5);
            wr(MAP[i], 8'h00);
        end
        wr(OFS_SRC_SEL, 8'hff);
        rdc(OFS_SRC_SEL, SRC_FIXED_MASK);
        check(src_unfilt, SRC_FIXED_MASK);
        wr(OFS_HOLD, 8'h8f);
        rdc(OFS_HOLD, 8'h0f);
        $display("register map finished");
        // routes and levels first, enable last
        wr(OFS_HOLD, 8'h00);
        wr(OFS_PIN_A_ROUTE, 8'h08);
        wr(OFS_PIN_CFG, 8'h05);
        pol_a = 1'h1;
        pol_b = 1'h1;
        wr(OFS_FRESH_EN, 8'h08);
        eng_cond = C3;
        step(3);
        rdc(OFS_FRESH_FLAG, 8'h00);
        upd(C3);
        rdc(OFS_FRESH_FLAG, 8'h08);
        step(1);
        check({6'h00, act_a, act_b}, 8'h02);
        eng_cond = 7'h00;
        step(3);
        rdc(OFS_FRESH_FLAG, 8'h08);
        upd(7'h00);
        rdc(OFS_FRESH_FLAG, 8'h00);
        step(1);
        check({6'h00, act_a, act_b}, 8'h00);
        upd(C3);
        wr(OFS_FRESH_EN, 8'h00);
        step(1);
        rdc(OFS_FRESH_FLAG, 8'h00);
        $display("nonlatched finished");
        for (int i = 0; i < 2; i++) begin
            cfg = (i == 0) ? 8'h07 : 8'h0f;
            wr(OFS_HOLD, cfg);
            wr(OFS_FRESH_EN, 8'h08);
            upd(C3);
            upd(7'h00);
            step(3);
            rdc(OFS_FRESH_FLAG, 8'h08);
            upd(C3);
            wr(OFS_HOLD, cfg | 8'h80);
            step(1);
            rdc(OFS_FRESH_FLAG, 8'h00);
            upd(C3);
            rdc(OFS_FRESH_FLAG, 8'h08);
            wr(OFS_FRESH_EN, 8'h00);
        end
        $display("latched finished");
        for (int i = 0; i < 12; i++) begin
            cfg = (i < 6) ? 8'(i + 1) : 8'(i + 3);
            wr(OFS_HOLD, cfg);
            wr(OFS_FRESH_EN, 8'h08);
            upd(C3);
            upd(7'h00);
            step(TC[i] - 4);
            rdc(OFS_FRESH_FLAG, 8'h08);
            step(6);
            rdc(OFS_FRESH_FLAG, 8'h00);
            wr(OFS_FRESH_EN, 8'h00);
        end
        wr(OFS_HOLD, 8'h09);
        wr(OFS_FRESH_EN, 8'h08);
        upd(C3);
        step(TC[6] + 6);
        rdc(OFS_FRESH_FLAG, 8'h08);
        upd(7'h00);
        step(2);
        rdc(OFS_FRESH_FLAG, 8'h00);
        wr(OFS_HOLD, 8'h00);
        for (int e = 6; e < 8; e++) begin
            wr(OFS_FRESH_EN, 8'h01 << e);
            c = 7'h00;
            c[e] = 1'h1;
            upd(c);
            upd(7'h00);
            step(FCLR - 4);
            rdc(OFS_FRESH_FLAG, 8'h01 << e);
            step(6);
            rdc(OFS_FRESH_FLAG, 8'h00);
        end
        $display("timed clears finished");
        wr(OFS_HOLD, 8'h08); // second nonlatched code
        wr(OFS_FRESH_EN, 8'h06);
        wr(OFS_PIN_A_ROUTE, 8'h06);
        wr(OFS_PIN_B_ROUTE, 8'h04);
        for (int k = 0; k < 16; k++) begin
            cfg = 8'(k);
            wr(OFS_PIN_CFG, cfg);
            pol_a = cfg[PCFG_A_POL];
            pol_b = cfg[PCFG_B_POL];
            upd(7'h00);
            step(2);
            check({act_a, act_b, irq_pin_a_oe, irq_pin_b_oe},
                {2'h0, ~cfg[PCFG_A_OD], ~cfg[PCFG_B_OD]});
            upd(7'h01);
            step(2);
            check({act_a, act_b, irq_pin_a_oe, irq_pin_b_oe},
                {3'h5, ~cfg[PCFG_B_OD]});
            upd(7'h02);
            step(2);
            check({act_a, act_b, irq_pin_a_oe, irq_pin_b_oe}, 8'h0f);
        end
        $display("pins finished");
        wr(OFS_HOLD, 8'h07);
        wr(OFS_FRESH_EN, 8'h01);
        upd(7'h00);
        rdc(OFS_FRESH_FLAG, 8'h01);
        drv(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        rdc(OFS_FRESH_FLAG, 8'h00);
        upd(7'h00);
        rdc(OFS_FRESH_FLAG, 8'h00);
        step(NEWS_LOW_CYC);
        upd(7'h00);
        rdc(OFS_FRESH_FLAG, 8'h01);
        drv(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        step(NEWS_LOW_CYC + 2);
        drv(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        upd(7'h00);
        rdc(OFS_FRESH_FLAG, 8'h00);
        step(WSET + 2);
        upd(7'h00);
        rdc(OFS_FRESH_FLAG, 8'h01);
        $display("fresh sample finished");
        summarize();
    end
endmodule // aic_top_test
